// ==== hw/gpint_port.sv ====
// Purpose: Per-port pin interrupt detection, status, masking and DMA triggers.
// Assumes: Pins are asynchronous to clk; bus is a plain strobe port.
// Notes: Type set writes use the low eight data bits as a pin mask.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module gpint_port
  import gpint_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst,
  // Register port.
  input  wire gpint_bus_t        bus,
  output logic [31:0]            rdata,
  // Pins and DMA activity.
  input  wire logic [NPINS-1:0]  pin_in,
  input  wire logic              dma_done,
  // Interrupt and DMA request outputs.
  output logic                   port_irq,
  output logic [NPINS-1:0]       pin_irq,
  output logic [NPINS-1:0]       dma_req
);

  logic [NPINS-1:0] sync1_ff, sync2_ff, prev_ff;
  logic [2:0]       type_ff [NPINS];
  logic             discrete_ff;
  logic [NSRC-1:0]  raw_ff, mask_ff;
  logic [NPINS-1:0] dma_en_ff;
  logic [2:0]       sel_pin_ff;
  logic             view_ff;
  logic [NPINS-1:0] event_w;
  logic [NSRC-1:0]  nxt_raw, clr_w, masked_w;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
      prev_ff  <= 8'h00;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      unique case (type_ff[i])
        DET_FALL: event_w[i] = prev_ff[i] & ~sync2_ff[i];
        DET_RISE: event_w[i] = ~prev_ff[i] & sync2_ff[i];
        DET_BOTH: event_w[i] = prev_ff[i] ^ sync2_ff[i];
        DET_LOW:  event_w[i] = ~sync2_ff[i];
        DET_HIGH: event_w[i] = sync2_ff[i];
        default:  event_w[i] = 1'b0;
      endcase
    end
  end

  // Type configuration applies to every pin in the mask at once.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NPINS; i++) type_ff[i] <= RST_TYPE[2:0];
      discrete_ff <= 1'b0;
    end else if (bus.wr && bus.addr == OFS_TYPE_SET) begin
      for (int i = 0; i < NPINS; i++) begin
        if (bus.wdata[i]) type_ff[i] <= bus.wdata[TYPE_LSB +: 3];
      end
      discrete_ff <= bus.wdata[DISCRETE_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_pin_ff <= 3'h0;
      view_ff    <= 1'b0;
    end else if (bus.wr && bus.addr == OFS_PIN_SEL) begin
      sel_pin_ff <= bus.wdata[2:0];
      view_ff    <= bus.wdata[TYPE_LSB + VIEW_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_ff <= RST_MASK;
    end else if (bus.wr && bus.addr == OFS_INT_EN) begin
      mask_ff <= mask_ff | bus.wdata[NSRC-1:0];
    end else if (bus.wr && bus.addr == OFS_INT_DIS) begin
      mask_ff <= mask_ff & ~bus.wdata[NSRC-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dma_en_ff <= RST_DMA;
    end else if (bus.wr && bus.addr == OFS_DMA_EN) begin
      dma_en_ff <= dma_en_ff | bus.wdata[NPINS-1:0];
    end else if (bus.wr && bus.addr == OFS_DMA_DIS) begin
      dma_en_ff <= dma_en_ff & ~bus.wdata[NPINS-1:0];
    end
  end

  // A new event in the clear cycle wins, so no event is lost.
  always_comb begin
    clr_w = (bus.wr && bus.addr == OFS_INT_CLR) ? bus.wdata[NSRC-1:0] : 9'h000;
    nxt_raw = (raw_ff & ~clr_w) | {dma_done, event_w};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) raw_ff <= 9'h000;
    else     raw_ff <= nxt_raw;
  end

  assign masked_w = raw_ff & mask_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (bus.rd) begin
      unique case (bus.addr)
        OFS_TYPE_GET:  rdata <= {20'h00000, discrete_ff, type_ff[sel_pin_ff], 8'h00};
        OFS_INT_EN:    rdata <= {23'h000000, mask_ff};
        OFS_STATUS:    rdata <= {23'h000000, view_ff ? masked_w : raw_ff};
        OFS_DMA_STATE: rdata <= {24'h000000, dma_en_ff};
        OFS_PIN_SEL:   rdata <= {23'h000000, view_ff, 5'h00, sel_pin_ff};
        default:       rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // Discrete mode routes pins apart; the DMA source stays on the shared line.
  assign port_irq = discrete_ff ? masked_w[SRC_DMA_BIT] : |masked_w;
  assign pin_irq  = discrete_ff ? masked_w[NPINS-1:0] : 8'h00;
  assign dma_req  = event_w & dma_en_ff;

  a_irq_masked: assert property (@(posedge clk) disable iff (rst)
    (!discrete_ff && (raw_ff & mask_ff) == 9'h000) |-> !port_irq) else $error("irq without enabled source");
  a_irq_raise: assert property (@(posedge clk) disable iff (rst)
    (!discrete_ff && |(raw_ff & mask_ff)) |-> port_irq) else $error("irq missing");
  a_clear_works: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == OFS_INT_CLR && bus.wdata[0] && !event_w[0]) |=> !raw_ff[0]) else $error("clear failed");
  a_event_latch: assert property (@(posedge clk) disable iff (rst)
    event_w[1] |=> raw_ff[1]) else $error("event not latched");
  a_dma_off: assert property (@(posedge clk) disable iff (rst)
    !dma_en_ff[2] |-> !dma_req[2]) else $error("dma request while disabled");
  a_dma_on: assert property (@(posedge clk) disable iff (rst)
    (dma_en_ff[3] && event_w[3]) |-> dma_req[3]) else $error("dma request missing");
  a_rise_edge: assert property (@(posedge clk) disable iff (rst)
    (type_ff[4] == DET_RISE && $rose(sync2_ff[4])) |=> raw_ff[4]) else $error("rise not seen");
  a_sync_delay: assert property (@(posedge clk) disable iff (rst)
    ##2 (sync2_ff == $past(pin_in, 2))) else $error("sync depth wrong");
  a_status_view: assert property (@(posedge clk) disable iff (rst)
    (bus.rd && bus.addr == OFS_STATUS && view_ff) |=> rdata[8:0] == $past(raw_ff & mask_ff)) else $error("masked view wrong");
  a_discrete_pin: assert property (@(posedge clk) disable iff (rst)
    discrete_ff |-> pin_irq == masked_w[7:0]) else $error("discrete routing wrong");
  a_indep_irq: assert property (@(posedge clk) disable iff (rst)
    (dma_req[5] && mask_ff[5]) |=> raw_ff[5]) else $error("dma pin lost interrupt");

  // Detector checks, one pin per type so that every decode arm is watched.

  a_fall_edge: assert property (@(posedge clk) disable iff (rst)
    (type_ff[0] == DET_FALL && $fell(sync2_ff[0]))
    |=> raw_ff[0])
    else $error("fall not seen");

  a_both_edge: assert property (@(posedge clk) disable iff (rst)
    (type_ff[6] == DET_BOTH && $changed(sync2_ff[6]))
    |=> raw_ff[6])
    else $error("edge not seen");

  a_low_level: assert property (@(posedge clk) disable iff (rst)
    (type_ff[7] == DET_LOW && !sync2_ff[7])
    |=> raw_ff[7])
    else $error("low level not latched");

  a_high_level: assert property (@(posedge clk) disable iff (rst)
    (type_ff[2] == DET_HIGH && sync2_ff[2])
    |=> raw_ff[2])
    else $error("high level not latched");

  a_illegal_type: assert property (@(posedge clk) disable iff (rst)
    (type_ff[0] > 3'h4)
    |-> !event_w[0])
    else $error("event from unused type code");

  a_edge_once: assert property (@(posedge clk) disable iff (rst)
    (type_ff[3] == DET_RISE && sync2_ff[3] && prev_ff[3])
    |-> !event_w[3])
    else $error("rise seen on steady level");

  // Status latch checks: sticky bits, selective clear, and set beating clear.

  a_dma_latch: assert property (@(posedge clk) disable iff (rst)
    dma_done
    |=> raw_ff[SRC_DMA_BIT])
    else $error("dma activity not latched");

  a_dma_quiet: assert property (@(posedge clk) disable iff (rst)
    (!raw_ff[SRC_DMA_BIT] && !dma_done)
    |=> !raw_ff[SRC_DMA_BIT])
    else $error("dma status without activity");

  a_raw_hold: assert property (@(posedge clk) disable iff (rst)
    (raw_ff[1] && !(bus.wr && bus.addr == OFS_INT_CLR && bus.wdata[1]))
    |=> raw_ff[1])
    else $error("status lost without clear");

  a_clear_other: assert property (@(posedge clk) disable iff (rst)
    (raw_ff[2] && bus.wr && bus.addr == OFS_INT_CLR && !bus.wdata[2])
    |=> raw_ff[2])
    else $error("unselected source cleared");

  a_set_wins: assert property (@(posedge clk) disable iff (rst)
    (event_w[4] && bus.wr && bus.addr == OFS_INT_CLR && bus.wdata[4])
    |=> raw_ff[4])
    else $error("event lost to clear");

  // Configuration register checks.

  a_mask_set: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == OFS_INT_EN)
    |=> (mask_ff & $past(bus.wdata[NSRC-1:0])) == $past(bus.wdata[NSRC-1:0]))
    else $error("enable not set");

  a_mask_clear: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == OFS_INT_DIS)
    |=> (mask_ff & $past(bus.wdata[NSRC-1:0])) == 9'h000)
    else $error("enable not cleared");

  a_dma_en_set: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == OFS_DMA_EN)
    |=> (dma_en_ff & $past(bus.wdata[NPINS-1:0])) == $past(bus.wdata[NPINS-1:0]))
    else $error("dma trigger not enabled");

  a_dma_en_clr: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == OFS_DMA_DIS)
    |=> (dma_en_ff & $past(bus.wdata[NPINS-1:0])) == 8'h00)
    else $error("dma trigger not disabled");

  a_type_write: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == OFS_TYPE_SET && bus.wdata[5])
    |=> type_ff[5] == $past(bus.wdata[TYPE_LSB +: 3]))
    else $error("selected pin type not written");

  a_type_keep: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == OFS_TYPE_SET && !bus.wdata[5])
    |=> $stable(type_ff[5]))
    else $error("unselected pin type changed");

  a_discrete_set: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == OFS_TYPE_SET)
    |=> discrete_ff == $past(bus.wdata[DISCRETE_BIT]))
    else $error("discrete flag not written");

  a_view_write: assert property (@(posedge clk) disable iff (rst)
    (bus.wr && bus.addr == OFS_PIN_SEL)
    |=> view_ff == $past(bus.wdata[TYPE_LSB + VIEW_BIT]))
    else $error("view select not written");

  // Output routing checks.

  a_shared_quiet: assert property (@(posedge clk) disable iff (rst)
    !discrete_ff
    |-> pin_irq == 8'h00)
    else $error("pin line active in shared mode");

  a_discrete_dma: assert property (@(posedge clk) disable iff (rst)
    discrete_ff
    |-> port_irq == masked_w[SRC_DMA_BIT])
    else $error("shared line wrong in discrete mode");

  a_port_or: assert property (@(posedge clk) disable iff (rst)
    !discrete_ff
    |-> port_irq == |masked_w)
    else $error("shared line not or of status");

  a_dma_no_mask: assert property (@(posedge clk) disable iff (rst)
    (event_w[1] && dma_en_ff[1] && !mask_ff[1])
    |-> dma_req[1])
    else $error("dma request tied to interrupt enable");

  // Read data checks; the answer stands only in the cycle after the strobe.

  a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
    !bus.rd
    |=> rdata == 32'h0000_0000)
    else $error("read data without read");

  a_rdata_wo: assert property (@(posedge clk) disable iff (rst)
    (bus.rd && bus.addr == OFS_INT_CLR)
    |=> rdata == 32'h0000_0000)
    else $error("write-only offset read back");

  a_status_raw: assert property (@(posedge clk) disable iff (rst)
    (bus.rd && bus.addr == OFS_STATUS && !view_ff)
    |=> rdata[8:0] == $past(raw_ff))
    else $error("raw view wrong");

  a_type_read: assert property (@(posedge clk) disable iff (rst)
    (bus.rd && bus.addr == OFS_TYPE_GET)
    |=> rdata[TYPE_LSB +: 3] == $past(type_ff[sel_pin_ff]))
    else $error("type read wrong");

  a_type_read_disc: assert property (@(posedge clk) disable iff (rst)
    (bus.rd && bus.addr == OFS_TYPE_GET)
    |=> rdata[DISCRETE_BIT] == $past(discrete_ff))
    else $error("discrete read wrong");

  a_mask_read: assert property (@(posedge clk) disable iff (rst)
    (bus.rd && bus.addr == OFS_INT_EN)
    |=> rdata[8:0] == $past(mask_ff))
    else $error("enable read wrong");

  a_dma_read: assert property (@(posedge clk) disable iff (rst)
    (bus.rd && bus.addr == OFS_DMA_STATE)
    |=> rdata[7:0] == $past(dma_en_ff))
    else $error("dma enable read wrong");

  a_pinsel_read: assert property (@(posedge clk) disable iff (rst)
    (bus.rd && bus.addr == OFS_PIN_SEL)
    |=> rdata[2:0] == $past(sel_pin_ff))
    else $error("pin select read wrong");

endmodule // gpint_port

// ==== hw/gpint_pkg.sv ====
// Purpose: Shared constants and types for the port interrupt and trigger block.
// Assumes: Eight pins per port and one port-level DMA activity source.
// Notes: Register offsets are word indices on the plain register port.
package gpint_pkg;
  localparam int NPINS = 8;
  localparam int NSRC  = 9;
  localparam int SRC_DMA_BIT = 8;

  localparam logic [3:0] OFS_TYPE_SET  = 4'h0;
  localparam logic [3:0] OFS_TYPE_GET  = 4'h1;
  localparam logic [3:0] OFS_INT_EN    = 4'h2;
  localparam logic [3:0] OFS_INT_DIS   = 4'h3;
  localparam logic [3:0] OFS_INT_CLR   = 4'h4;
  localparam logic [3:0] OFS_STATUS    = 4'h5;
  localparam logic [3:0] OFS_DMA_EN    = 4'h6;
  localparam logic [3:0] OFS_DMA_DIS   = 4'h7;
  localparam logic [3:0] OFS_DMA_STATE = 4'h8;
  localparam logic [3:0] OFS_PIN_SEL   = 4'h9;

  // Field positions in write data.
  localparam int TYPE_LSB     = 8;
  localparam int DISCRETE_BIT = 11;
  localparam int VIEW_BIT     = 0;

  localparam logic [7:0]  RST_TYPE = 8'h00;
  localparam logic [8:0]  RST_MASK = 9'h000;
  localparam logic [7:0]  RST_DMA  = 8'h00;

  typedef enum logic [2:0] {
    DET_FALL = 3'b000,
    DET_RISE = 3'b001,
    DET_BOTH = 3'b010,
    DET_LOW  = 3'b011,
    DET_HIGH = 3'b100
  } gpint_det_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } gpint_bus_t;
endpackage

// ==== bench/gpint_far.sv ====
// Purpose: Far-side model: a DMA controller that gives one completion per cycle in which any pin request rises.
// Assumes: Same clock as the port.
// Notes: Completion lags a request rise by three cycles, as a short transfer would.
`timescale 1ns/10ps
module gpint_far (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Request in, completion out.
  input  wire logic [7:0] dma_req,
  output logic            dma_done
);
  logic [7:0] req_ff;
  logic [1:0] lag_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_ff   <= 8'h00;
      lag_ff   <= 2'h0;
      dma_done <= 1'h0;
    end else begin
      req_ff   <= dma_req;
      lag_ff   <= {lag_ff[0], |(dma_req & ~req_ff)};
      dma_done <= lag_ff[1];
    end
  end
endmodule // gpint_far

// ==== bench/gpint_port_test.sv ====
// Purpose: Register-level tests of pin detection, masking, clearing and DMA triggers.
// Assumes: Bus strobes are single cycles; pin changes settle within four cycles.
// Notes: Pins are held still across every type write; level events latched in the type loop are cleared before the checks.
`timescale 1ns/10ps
module gpint_port_test
  import gpint_pkg::*;
;
  logic        clk, rst, dma_done, port_irq;
  gpint_bus_t  bus;
  logic [31:0] rdata;
  logic [7:0]  pin_in, pin_irq, dma_req;
  int          error_cnt, n_checks;
  gpint_port u_dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .pin_in(pin_in),
    .dma_done(dma_done), .port_irq(port_irq), .pin_irq(pin_irq), .dma_req(dma_req));
  gpint_far u_far (.clk(clk), .rst(rst), .dma_req(dma_req), .dma_done(dma_done));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '{default: '0};
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string w);
    bus <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 32'h0};
    @(posedge clk);
    bus <= '{default: '0};
    #1;
    chk(w, e, rdata);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    bus = '{default: '0};
    pin_in = 8'h00;
    rst = 1'h1;
    error_cnt = 0;
    n_checks = 0;
    tick(12);
    rst <= 1'h0;
    tick(1);
    rd(OFS_INT_EN, 32'h0, "mask");
    rd(OFS_DMA_STATE, 32'h0, "dma en");
    rd(4'hF, 32'h0, "unmapped");
    for (int t = 0; t < 5; t++) begin
      wr(OFS_TYPE_SET, 32'h06 | (32'(t) << TYPE_LSB));
      wr(OFS_PIN_SEL, 32'h2);
      rd(OFS_TYPE_GET, 32'(t) << TYPE_LSB, "type");
    end
    wr(OFS_INT_CLR, 32'h1FF);
    wr(OFS_PIN_SEL, 32'h0);
    rd(OFS_TYPE_GET, 32'h0, "type pin0");
    $display("test types done");
    pin_in <= 8'h02;
    tick(4);
    rd(OFS_STATUS, 32'h002, "raw");
    chk("irq off", 32'h0, 32'(port_irq));
    wr(OFS_INT_EN, 32'h002);
    chk("irq on", 32'h1, 32'(port_irq));
    wr(OFS_INT_CLR, 32'h002);
    rd(OFS_STATUS, 32'h002, "level");
    pin_in <= 8'h00;
    tick(4);
    wr(OFS_INT_CLR, 32'h1FF);
    rd(OFS_STATUS, 32'h0, "clr");
    chk("irq clr", 32'h0, 32'(port_irq));
    $display("test level done");
    wr(OFS_TYPE_SET, 32'h108);
    wr(OFS_DMA_EN, 32'h08);
    rd(OFS_DMA_STATE, 32'h08, "dma en");
    wr(OFS_INT_EN, 32'h108);
    pin_in <= 8'h08;
    tick(8);
    rd(OFS_STATUS, 32'h108, "dma");
    wr(OFS_INT_DIS, 32'h102);
    wr(OFS_PIN_SEL, 32'h100);
    rd(OFS_STATUS, 32'h008, "masked");
    wr(OFS_DMA_DIS, 32'h08);
    wr(OFS_INT_CLR, 32'h108);
    pin_in <= 8'h00;
    tick(4);
    pin_in <= 8'h08;
    tick(8);
    wr(OFS_PIN_SEL, 32'h003);
    rd(OFS_STATUS, 32'h008, "no dma");
    chk("dma req off", 32'h0, 32'(dma_req));
    $display("test dma done");
    wr(OFS_TYPE_SET, 32'h800);
    rd(OFS_TYPE_GET, 32'h900, "discrete");
    chk("pin irq", 32'h08, 32'(pin_irq));
    chk("port irq", 32'h0, 32'(port_irq));
    $display("test discrete done");
    print_verdict();
  end
endmodule // gpint_port_test
